// ===== src/hsfs_sequencer.sv
// Sequencing and fault management of a negative-rail hot-swap controller
`default_nettype none
module hsfs_sequencer #(
  parameter logic [31:0] P_START_CYC = hsfs_pkg::START_CYC,
  parameter logic [31:0] P_PROBE_CYC = hsfs_pkg::PROBE_CYC,
  parameter logic [31:0] P_CB_CYC    = hsfs_pkg::CB_CYC,
  parameter logic [31:0] P_OV_CYC    = hsfs_pkg::OV_CYC,
  parameter logic [31:0] P_UV_CYC    = hsfs_pkg::UV_CYC,
  parameter logic [31:0] P_PG_CYC    = hsfs_pkg::PG_CYC,
  parameter logic [31:0] P_OFFCB_CYC = hsfs_pkg::OFFCB_CYC,
  parameter logic [31:0] P_RETRY_CYC = hsfs_pkg::RETRY_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // Comparator results and straps, asynchronous
  input  wire logic        upper_on_i,
  input  wire logic        lower_off_i,
  input  wire logic        high_limit_sense_i,
  input  wire logic        drain_above_breaker_i,
  input  wire logic        drain_above_short_i,
  input  wire logic        drain_above_74_i,
  input  wire logic        gate_at_90_i,
  input  wire logic        probe_level_ok_i,
  input  wire logic        breaker_trim_pin_open_i,
  input  wire logic        flag_sense_strap_open_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [31:0] reg_rdata_o,
  // Gate and probe control
  output logic             gate_ramp_o,
  output logic             gate_boost_o,
  output logic             gate_pull_o,
  output logic             probe_en_o,
  // Power-good flag, polarity applied
  output logic             power_ok_flag_o
);
  // ******************************************************************
  // Input synchroniser
  // ******************************************************************
  hsfs_pkg::hsfs_cmp_t cmp_raw;
  hsfs_pkg::hsfs_cmp_t cmp_s1;
  hsfs_pkg::hsfs_cmp_t s;

  // Bundle the pins
  assign cmp_raw = '{upper: upper_on_i, lower: lower_off_i, ov: high_limit_sense_i,
                     cb: drain_above_breaker_i, sc: drain_above_short_i,
                     d74: drain_above_74_i, g90: gate_at_90_i,
                     probe_ok: probe_level_ok_i, trim_open: breaker_trim_pin_open_i,
                     pol_open: flag_sense_strap_open_i};

  // Two flops, only the second is read
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cmp_s1 <= '0;
      s      <= '0;
    end else begin
      cmp_s1 <= cmp_raw;
      s      <= cmp_s1;
    end
  end

  // ******************************************************************
  // Undervoltage latch and filters
  // ******************************************************************
  logic [31:0] uv_cnt;
  logic [31:0] next_uv_cnt;
  logic [31:0] cb_cnt;
  logic [31:0] next_cb_cnt;
  logic        on_q;
  logic        next_on;
  logic        uv_low;
  logic        cb_trip;
  logic        offcb_trip;

  // Saturating low-time count of the upper input
  always_comb begin
    uv_low = (uv_cnt >= P_UV_CYC);
    if (s.upper) begin
      next_uv_cnt = '0;
    end else if (uv_low) begin
      next_uv_cnt = uv_cnt;
    end else begin
      next_uv_cnt = uv_cnt + 32'h0000_0001;
    end
    // Mixed input states keep the latch as it is
    if (s.upper && s.lower) begin
      next_on = 1'b1;
    end else if (!s.lower && uv_low) begin
      next_on = 1'b0;
    end else begin
      next_on = on_q;
    end
  end

  // Continuous breaker-level time; any dip restarts it
  always_comb begin
    cb_trip    = s.cb && (cb_cnt >= P_CB_CYC - 32'h0000_0001);
    offcb_trip = s.cb && (cb_cnt >= P_OFFCB_CYC - 32'h0000_0001);
    if (!s.cb) begin
      next_cb_cnt = '0;
    end else if (cb_cnt == 32'hFFFF_FFFF) begin
      next_cb_cnt = cb_cnt;
    end else begin
      next_cb_cnt = cb_cnt + 32'h0000_0001;
    end
  end

  // Filter registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      uv_cnt <= '0;
      cb_cnt <= '0;
      on_q   <= 1'b0;
    end else begin
      uv_cnt <= next_uv_cnt;
      cb_cnt <= next_cb_cnt;
      on_q   <= next_on;
    end
  end

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  hsfs_pkg::hsfs_state_t state_q;
  hsfs_pkg::hsfs_state_t next_state;
  hsfs_pkg::hsfs_cause_t cause_q;
  hsfs_pkg::hsfs_cause_t next_cause;
  logic [31:0] tmr_q;
  logic [31:0] next_tmr;
  logic        pg_q;
  logic        next_pg;
  logic        armed_q;
  logic        next_armed;
  logic        retry_en;

  // Next state; one timer reused, cleared on every state change
  always_comb begin
    next_state = state_q;
    next_cause = cause_q;
    next_pg    = pg_q;
    next_armed = armed_q;
    next_tmr   = tmr_q + 32'h0000_0001;
    unique case (state_q)
      hsfs_pkg::ST_OFF: begin
        next_pg = 1'b0;
        if (on_q && !s.ov) begin
          next_state = hsfs_pkg::ST_WAIT;
        end
      end
      hsfs_pkg::ST_WAIT: begin
        // Settle delay from a valid turn-on condition
        if (!on_q) begin
          next_state = hsfs_pkg::ST_OFF;
        end else if (s.ov) begin
          next_tmr = '0;
        end else if (tmr_q >= P_START_CYC - 32'h0000_0001) begin
          next_state = hsfs_pkg::ST_PROBE;
        end
      end
      hsfs_pkg::ST_PROBE: begin
        // Early pass on load level, fail at window end
        if (s.probe_ok) begin
          next_state = hsfs_pkg::ST_RAMP;
        end else if (tmr_q >= P_PROBE_CYC - 32'h0000_0001) begin
          next_state = hsfs_pkg::ST_FAULT;
          next_cause = hsfs_pkg::CA_PROBE;
        end
      end
      hsfs_pkg::ST_RAMP: begin
        if (!on_q) begin
          next_state = hsfs_pkg::ST_OFF;
        end else if (s.ov) begin
          next_state = hsfs_pkg::ST_OV;
        end else if (!s.trim_open && !s.d74) begin
          next_state = hsfs_pkg::ST_FULL;
        end else if (s.g90) begin
          if (s.trim_open) begin
            next_state = hsfs_pkg::ST_FULL;
          end else begin
            next_state = hsfs_pkg::ST_FAULT;
            next_cause = hsfs_pkg::CA_RAMP;
          end
        end
      end
      hsfs_pkg::ST_FULL: begin
        if (s.ov) begin
          next_state = hsfs_pkg::ST_OV;
        end else if (!on_q) begin
          next_state = hsfs_pkg::ST_SHUT;
        end else if (!s.trim_open && s.sc) begin
          next_state = hsfs_pkg::ST_FAULT;
          next_cause = hsfs_pkg::CA_SC;
        end else if (!s.trim_open && cb_trip) begin
          next_state = hsfs_pkg::ST_FAULT;
          next_cause = hsfs_pkg::CA_CB;
        end else if (tmr_q >= P_PG_CYC - 32'h0000_0001) begin
          next_pg  = 1'b1;
          next_tmr = tmr_q;
        end
      end
      hsfs_pkg::ST_OV: begin
        // Short excursions ramp back, long ones fault
        if (!s.ov) begin
          next_state = hsfs_pkg::ST_RAMP;
        end else if (tmr_q >= P_OV_CYC - 32'h0000_0001) begin
          next_state = hsfs_pkg::ST_FAULT;
          next_cause = hsfs_pkg::CA_OV;
        end
      end
      hsfs_pkg::ST_FAULT: begin
        next_pg = 1'b0;
        if (retry_en) begin
          if (!on_q) begin
            next_state = hsfs_pkg::ST_OFF;
          end else if (cause_q == hsfs_pkg::CA_OV && s.ov) begin
            next_tmr = '0;
          end else if (tmr_q >= P_RETRY_CYC - 32'h0000_0001) begin
            next_state = hsfs_pkg::ST_PROBE;
          end
        end else begin
          // Off sequence arms the clear, overvoltage must be gone
          if (!on_q) begin
            next_armed = 1'b1;
          end
          if (armed_q && !s.ov) begin
            next_state = hsfs_pkg::ST_PROBE;
          end
        end
      end
      hsfs_pkg::ST_SHUT: begin
        // Flag held until the drain rises, or at once with trim open
        if (s.trim_open || s.sc || offcb_trip) begin
          next_pg    = 1'b0;
          next_state = hsfs_pkg::ST_OFF;
        end
      end
    endcase
    if (next_state != state_q) begin
      next_tmr = '0;
    end
    // Fault entry drops the flag and disarms the latched clear
    if (next_state == hsfs_pkg::ST_FAULT && state_q != hsfs_pkg::ST_FAULT) begin
      next_pg    = 1'b0;
      next_armed = 1'b0;
    end
  end

  // Sequencer registers; start in the off state
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_q <= hsfs_pkg::ST_OFF;
      cause_q <= hsfs_pkg::CA_NONE;
      tmr_q   <= '0;
      pg_q    <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      state_q <= next_state;
      cause_q <= next_cause;
      tmr_q   <= next_tmr;
      pg_q    <= next_pg;
      armed_q <= next_armed;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  logic next_ramp;
  logic next_flag;

  // Outputs follow the next state so they line up with state_q
  always_comb begin
    next_ramp = (next_state == hsfs_pkg::ST_RAMP) || (next_state == hsfs_pkg::ST_FULL);
    next_flag = next_pg ^ s.pol_open;
  end

  // Output flops
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      gate_ramp_o     <= 1'b0;
      gate_boost_o    <= 1'b0;
      gate_pull_o     <= 1'b1;
      probe_en_o      <= 1'b0;
      power_ok_flag_o <= 1'b0;
    end else begin
      gate_ramp_o     <= next_ramp;
      gate_boost_o    <= (next_state == hsfs_pkg::ST_FULL);
      gate_pull_o     <= !next_ramp;
      probe_en_o      <= (next_state == hsfs_pkg::ST_PROBE);
      power_ok_flag_o <= next_flag;
    end
  end

  // ******************************************************************
  // Register port
  // ******************************************************************
  logic        ctrl_retry;
  logic        next_ctrl_retry;
  logic [31:0] next_rdata;

  assign retry_en = ctrl_retry;

  // Decode; unmapped reads return zero
  always_comb begin
    next_ctrl_retry = ctrl_retry;
    next_rdata      = '0;
    if (reg_we_i && reg_addr_i == hsfs_pkg::ADDR_CTRL) begin
      next_ctrl_retry = reg_wdata_i[hsfs_pkg::CTRL_RETRY];
    end
    if (reg_re_i) begin
      if (reg_addr_i == hsfs_pkg::ADDR_CTRL) begin
        next_rdata[hsfs_pkg::CTRL_RETRY] = ctrl_retry;
      end else if (reg_addr_i == hsfs_pkg::ADDR_STATUS) begin
        next_rdata[hsfs_pkg::STS_STATE +: 3] = state_q;
        next_rdata[hsfs_pkg::STS_PG]         = pg_q;
        next_rdata[hsfs_pkg::STS_ON]         = on_q;
        next_rdata[hsfs_pkg::STS_CAUSE +: 3] = cause_q;
        next_rdata[hsfs_pkg::STS_GATE]       = gate_ramp_o;
      end
    end
  end

  // Register flops; read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl_retry  <= hsfs_pkg::CTRL_RETRY_RST;
      reg_rdata_o <= '0;
    end else begin
      ctrl_retry  <= next_ctrl_retry;
      reg_rdata_o <= next_rdata;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb_sys @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence seq_live_gate;
    (state_q == hsfs_pkg::ST_RAMP) || (state_q == hsfs_pkg::ST_FULL);
  endsequence

  sequence seq_ov_gone;
    (state_q == hsfs_pkg::ST_OV) && !s.ov;
  endsequence

  chk_fault_gate_off: assert property (
    (state_q == hsfs_pkg::ST_FAULT) |-> (gate_pull_o && !gate_ramp_o && !pg_q))
    else $error("Gate or flag live during fault");

  chk_short_fast: assert property (
    (state_q == hsfs_pkg::ST_FULL && s.sc && !s.trim_open && !s.ov && on_q)
    |=> (state_q == hsfs_pkg::ST_FAULT && cause_q == hsfs_pkg::CA_SC))
    else $error("Short circuit did not fault at once");

  chk_cb_window: assert property (
    (state_q == hsfs_pkg::ST_FULL && cb_trip && !s.trim_open && !s.ov && on_q && !s.sc)
    |=> (state_q == hsfs_pkg::ST_FAULT && $past(cb_cnt) == P_CB_CYC - 32'h0000_0001))
    else $error("Breaker window trip wrong");

  chk_trim_ignore: assert property (
    (state_q == hsfs_pkg::ST_FULL && s.trim_open)
    |=> (state_q != hsfs_pkg::ST_FAULT))
    else $error("Fault taken with trim pin open");

  chk_ov_cycle: assert property (
    (seq_live_gate ##0 (s.ov && on_q)) |=> (state_q == hsfs_pkg::ST_OV) ##0 gate_pull_o)
    else $error("Overvoltage did not pull gate");

  chk_ov_recover: assert property (
    seq_ov_gone |=> (state_q == hsfs_pkg::ST_RAMP) ##1 gate_ramp_o || !on_q || s.ov)
    else $error("Overvoltage recovery missed");

  chk_retry_hold: assert property (
    (state_q == hsfs_pkg::ST_FAULT && cause_q == hsfs_pkg::CA_OV && s.ov && retry_en && on_q)
    |=> (tmr_q == 32'h0000_0000))
    else $error("Retry timer ran during overvoltage");

  chk_flag_polarity: assert property (
    power_ok_flag_o == ($past(s.pol_open) ^ pg_q))
    else $error("Power flag polarity wrong");

  chk_uv_filter: assert property (
    $fell(on_q) |-> ($past(uv_cnt) >= P_UV_CYC && !$past(s.lower)))
    else $error("Turn-off without filtered low");

  chk_pg_delay: assert property (
    $rose(pg_q) |-> ($past(state_q) == hsfs_pkg::ST_FULL
                     && $past(tmr_q) == P_PG_CYC - 32'h0000_0001))
    else $error("Power flag set at wrong time");
endmodule : hsfs_sequencer
`default_nettype wire

// ===== include/hsfs_pkg.sv
// Constants, types and timing counts for the hot-swap fault sequencer
// Functional notes
// - Fault if drain still high at 90% ramp (with trim pin open the code enters full instead)
// - Breaker level over 1.2ms in full: fault
// - Short-circuit level in full: instant fault
// - High limit over 1.5ms: overvoltage fault
// - Fault holds gate off, power flag off
// - Trim pin open ignores breaker, short faults
// - Overvoltage fault retry waits for clearance
// - Breaker or short fault: retry timer immediate
// - Retry expiry runs probe, then ramp
// - Latched fault clears by off sequence only
// - Latched clear needs overvoltage gone, then probe
// - Power flag latches 1.26ms after full enhancement
// - Trim open: flag 1.26ms after 90% ramp
// - After off command, flag drops on drain rise
// - Trim open: flag drops only on listed causes
// - Strap selects power flag polarity
// - Both inputs high on, both low off
// - Upper input low needs 1.5ms filter
// - 220ms settle before probe starts
// - High limit at once starts gate-off cycle
// - Short overvoltage recovers, long one faults
// - Probe lasts 220ms, passes on load level
`default_nettype none
package hsfs_pkg;
  // ******************************************************************
  // Clock and timing
  // ******************************************************************
  localparam int unsigned CLK_MHZ     = 20;
  localparam int unsigned START_US    = 220_000;
  localparam int unsigned PROBE_US    = 220_000;
  localparam int unsigned CB_US       = 1_200;
  localparam int unsigned OV_US       = 1_500;
  localparam int unsigned UV_US       = 1_500;
  localparam int unsigned PG_US       = 1_260;
  localparam int unsigned OFFCB_US    = 1_400;
  localparam int unsigned RETRY_US    = 3_500_000;
  // Exact multiples of the period, so no rounding is involved
  localparam logic [31:0] START_CYC   = 32'(START_US * CLK_MHZ);
  localparam logic [31:0] PROBE_CYC   = 32'(PROBE_US * CLK_MHZ);
  localparam logic [31:0] CB_CYC      = 32'(CB_US * CLK_MHZ);
  localparam logic [31:0] OV_CYC      = 32'(OV_US * CLK_MHZ);
  localparam logic [31:0] UV_CYC      = 32'(UV_US * CLK_MHZ);
  localparam logic [31:0] PG_CYC      = 32'(PG_US * CLK_MHZ);
  localparam logic [31:0] OFFCB_CYC   = 32'(OFFCB_US * CLK_MHZ);
  localparam logic [31:0] RETRY_CYC   = 32'(RETRY_US * CLK_MHZ);

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam int unsigned CTRL_RETRY  = 0;
  localparam logic        CTRL_RETRY_RST = 1'b1;
  localparam int unsigned STS_STATE   = 0;
  localparam int unsigned STS_PG      = 3;
  localparam int unsigned STS_ON      = 4;
  localparam int unsigned STS_CAUSE   = 5;
  localparam int unsigned STS_GATE    = 8;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_WAIT  = 3'b001,
    ST_PROBE = 3'b011,
    ST_RAMP  = 3'b010,
    ST_FULL  = 3'b110,
    ST_OV    = 3'b111,
    ST_FAULT = 3'b101,
    ST_SHUT  = 3'b100
  } hsfs_state_t;

  typedef enum logic [2:0] {
    CA_NONE  = 3'd0,
    CA_PROBE = 3'd1,
    CA_RAMP  = 3'd2,
    CA_CB    = 3'd3,
    CA_SC    = 3'd4,
    CA_OV    = 3'd5
  } hsfs_cause_t;

  // Comparator and strap bundle
  typedef struct packed {
    logic upper;      // Turn-on input above threshold
    logic lower;      // Turn-off input above threshold
    logic ov;         // High limit sense above threshold
    logic cb;         // Drain above breaker level
    logic sc;         // Drain above short-circuit level
    logic d74;        // Drain above 74% of breaker level
    logic g90;        // Gate at 90% of full enhancement
    logic probe_ok;   // Load voltage reached probe level
    logic trim_open;  // Breaker trim pin open
    logic pol_open;   // Flag polarity strap open
  } hsfs_cmp_t;
endpackage : hsfs_pkg
`default_nettype wire

// ===== tb/hsfs_fet_model.sv
// Behavioural model of the external MOSFET, load and drain comparators
`default_nettype none
module hsfs_fet_model (
  // Clock
  input  wire logic clk_sys_i,
  // Drive from the sequencer
  input  wire logic gate_ramp_i,
  input  wire logic gate_boost_i,
  input  wire logic probe_en_i,
  // Scenario knobs
  input  wire logic heavy_i,
  input  wire logic shorted_i,
  // Comparator views back to the sequencer
  output logic      drain_above_74_o,
  output logic      gate_at_90_o,
  output logic      probe_level_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ramp_cnt;
  logic [3:0] probe_cnt;

  // Gate charge and probe dwell, both saturating
  always_ff @(posedge clk_sys_i) begin
    ramp_cnt  <= !gate_ramp_i ? 4'h0 : ((ramp_cnt == 4'hf) ? ramp_cnt : ramp_cnt + 4'h1);
    probe_cnt <= !probe_en_i ? 4'h0 : ((probe_cnt == 4'hf) ? probe_cnt : probe_cnt + 4'h1);
  end

  // Drain stays high while gate is low, or always under a heavy load
  assign gate_at_90_o     = gate_boost_i | (ramp_cnt >= 4'h8);
  assign drain_above_74_o = heavy_i | (!gate_boost_i & (ramp_cnt < 4'h4));
  // A shorted load never lets the probe voltage build up
  assign probe_level_ok_o = probe_en_i & !shorted_i & (probe_cnt >= 4'h4);
endmodule : hsfs_fet_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking testbench of the hot-swap fault sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************************************************
  // Signals
  // ******************************************************************
  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        upper_on_i = 1'b0;
  logic        lower_off_i = 1'b0;
  logic        ov = 1'b0;
  logic        cb = 1'b0;
  logic        sc = 1'b0;
  logic        trim = 1'b0;
  logic        strap = 1'b1;
  logic        heavy = 1'b0;
  logic        shorted = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        gate_ramp_o, gate_boost_o, gate_pull_o, probe_en_o, power_ok_flag_o;
  wire logic   d74, g90, pok;
  int          n_errors = 0;
  int          n_tests = 0;

  // Short counts keep the run small; expectations derive from these
  hsfs_sequencer #(.P_START_CYC(32'd40), .P_PROBE_CYC(32'd40), .P_CB_CYC(32'd8),
    .P_OV_CYC(32'd10), .P_UV_CYC(32'd10), .P_PG_CYC(32'd12), .P_OFFCB_CYC(32'd9),
    .P_RETRY_CYC(32'd50)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .upper_on_i(upper_on_i), .lower_off_i(lower_off_i), .high_limit_sense_i(ov),
    .drain_above_breaker_i(cb), .drain_above_short_i(sc), .drain_above_74_i(d74),
    .gate_at_90_i(g90), .probe_level_ok_i(pok), .breaker_trim_pin_open_i(trim),
    .flag_sense_strap_open_i(strap), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(reg_rdata_o), .gate_ramp_o(gate_ramp_o),
    .gate_boost_o(gate_boost_o), .gate_pull_o(gate_pull_o), .probe_en_o(probe_en_o),
    .power_ok_flag_o(power_ok_flag_o));
  hsfs_fet_model fet (.clk_sys_i(clk_sys_i), .gate_ramp_i(gate_ramp_o),
    .gate_boost_i(gate_boost_o), .probe_en_i(probe_en_o), .heavy_i(heavy),
    .shorted_i(shorted), .drain_above_74_o(d74), .gate_at_90_o(g90),
    .probe_level_ok_o(pok));

  always #25 clk_sys_i = ~clk_sys_i;

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Called just after a rising edge; read data stand only in the next cycle
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk_sys_i);
    re   <= 1'b0;
    @(posedge clk_sys_i);
    d = reg_rdata_o;
  endtask : rd

  // Extra edge at the end so a following write never re-raises the strobe at once
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk_sys_i);
    we    <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr

  // Polls status; each poll costs two cycles, so n is in cycles
  task automatic wait_st(input hsfs_pkg::hsfs_state_t st, input int lim, output int n);
    logic [31:0] d;
    n = 0;
    rd(hsfs_pkg::ADDR_STATUS, d);
    while (d[2:0] !== st && n < lim) begin
      rd(hsfs_pkg::ADDR_STATUS, d);
      n += 2;
    end
    chk(32'(d[2:0]), 32'(st));
  endtask : wait_st

  task automatic cause_is(input hsfs_pkg::hsfs_cause_t c);
    logic [31:0] d;
    rd(hsfs_pkg::ADDR_STATUS, d);
    chk(32'(d[7:5]), 32'(c));
  endtask : cause_is

  task automatic wait_flag(input logic v, input int lim, output int n);
    n = 0;
    while (power_ok_flag_o !== v && n < lim) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(32'(power_ok_flag_o), 32'(v));
  endtask : wait_flag

  // Every scenario starts from a clean power-up
  task automatic rst(input logic t, input logic s);
    @(posedge clk_sys_i) reset_i <= 1'b1;
    {upper_on_i, lower_off_i, ov, cb, sc, heavy, shorted} <= 7'h00;
    trim <= t;
    strap <= s;
    cyc(20);
    reset_i <= 1'b0;
    cyc(4);
  endtask : rst

  task automatic up(output int n);
    upper_on_i <= 1'b1;
    lower_off_i <= 1'b1;
    wait_st(hsfs_pkg::ST_FULL, 300, n);
  endtask : up

  task automatic end_of_test();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic s_regs();
    logic [31:0] d;
    rst(1'b0, 1'b1);
    chk(32'(power_ok_flag_o), 32'h0000_0001);
    chk(32'(gate_pull_o), 32'h0000_0001);
    rd(hsfs_pkg::ADDR_CTRL, d);
    chk(d, 32'h0000_0001);
    rd(4'h8, d);
    chk(d, 32'h0000_0000);
    wr(hsfs_pkg::ADDR_STATUS, 32'hffff_ffff);
    rd(hsfs_pkg::ADDR_STATUS, d);
    chk(d, 32'h0000_0000);
  endtask : s_regs

  task automatic s_normal();
    int n;
    rst(1'b0, 1'b0);
    upper_on_i <= 1'b1;
    cyc(30);
    wait_st(hsfs_pkg::ST_OFF, 0, n);
    lower_off_i <= 1'b1;
    wait_st(hsfs_pkg::ST_PROBE, 200, n);
    chk(32'(n >= 40), 32'h0000_0001);
    wait_st(hsfs_pkg::ST_FULL, 100, n);
    chk(32'(gate_boost_o), 32'h0000_0001);
    wait_flag(1'b1, 30, n);
    chk(32'(n >= 8 && n <= 13), 32'h0000_0001);
    // Both inputs low, but the upper one too briefly to turn off
    {upper_on_i, lower_off_i} <= 2'h0;
    cyc(6);
    {upper_on_i, lower_off_i} <= 2'h3;
    cyc(10);
    wait_st(hsfs_pkg::ST_FULL, 0, n);
    cb <= 1'b1;
    cyc(5);
    cb <= 1'b0;
    cyc(8);
    wait_st(hsfs_pkg::ST_FULL, 0, n);
    cb <= 1'b1;
    wait_st(hsfs_pkg::ST_FAULT, 20, n);
    cause_is(hsfs_pkg::CA_CB);
    chk(32'({gate_pull_o, power_ok_flag_o}), 32'h0000_0002);
    cb <= 1'b0;
    wait_st(hsfs_pkg::ST_PROBE, 60, n);
    chk(32'(n >= 40 && n <= 56), 32'h0000_0001);
    wait_st(hsfs_pkg::ST_FULL, 100, n);
    sc <= 1'b1;
    wait_st(hsfs_pkg::ST_FAULT, 8, n);
    cause_is(hsfs_pkg::CA_SC);
  endtask : s_normal

  task automatic s_ov();
    int n;
    rst(1'b0, 1'b0);
    up(n);
    ov <= 1'b1;
    cyc(4);
    chk(32'(gate_pull_o), 32'h0000_0001);
    cyc(2);
    ov <= 1'b0;
    wait_st(hsfs_pkg::ST_FULL, 60, n);
    ov <= 1'b1;
    wait_st(hsfs_pkg::ST_FAULT, 20, n);
    chk(32'(n >= 8), 32'h0000_0001);
    cause_is(hsfs_pkg::CA_OV);
    cyc(80);
    wait_st(hsfs_pkg::ST_FAULT, 0, n);
    ov <= 1'b0;
    wait_st(hsfs_pkg::ST_PROBE, 70, n);
    chk(32'(n >= 40), 32'h0000_0001);
  endtask : s_ov

  task automatic s_trim_faults();
    int n;
    // Strap open here, so the flag is active low
    rst(1'b1, 1'b1);
    up(n);
    wait_flag(1'b0, 30, n);
    chk(32'(n >= 8 && n <= 13), 32'h0000_0001);
    sc <= 1'b1;
    cb <= 1'b1;
    cyc(30);
    chk(32'(power_ok_flag_o), 32'h0000_0000);
    wait_st(hsfs_pkg::ST_FULL, 0, n);
    // Fault runs never reach full enhancement
    rst(1'b0, 1'b0);
    heavy <= 1'b1;
    {upper_on_i, lower_off_i} <= 2'h3;
    wait_st(hsfs_pkg::ST_FAULT, 100, n);
    cause_is(hsfs_pkg::CA_RAMP);
    rst(1'b0, 1'b0);
    shorted <= 1'b1;
    {upper_on_i, lower_off_i} <= 2'h3;
    wait_st(hsfs_pkg::ST_FAULT, 120, n);
    cause_is(hsfs_pkg::CA_PROBE);
  endtask : s_trim_faults

  task automatic s_latch_shut();
    int n;
    rst(1'b0, 1'b0);
    wr(hsfs_pkg::ADDR_CTRL, 32'h0000_0000);
    up(n);
    sc <= 1'b1;
    wait_st(hsfs_pkg::ST_FAULT, 8, n);
    sc <= 1'b0;
    cyc(80);
    wait_st(hsfs_pkg::ST_FAULT, 0, n);
    {upper_on_i, lower_off_i} <= 2'h0;
    wait_st(hsfs_pkg::ST_PROBE, 40, n);
    chk(32'(n >= 10), 32'h0000_0001);
    // Latched overvoltage fault: off sequence alone must not clear it
    rst(1'b0, 1'b0);
    wr(hsfs_pkg::ADDR_CTRL, 32'h0000_0000);
    up(n);
    ov <= 1'b1;
    wait_st(hsfs_pkg::ST_FAULT, 30, n);
    {upper_on_i, lower_off_i} <= 2'h0;
    cyc(30);
    wait_st(hsfs_pkg::ST_FAULT, 0, n);
    ov <= 1'b0;
    wait_st(hsfs_pkg::ST_PROBE, 10, n);
    rst(1'b0, 1'b0);
    up(n);
    wait_flag(1'b1, 30, n);
    {upper_on_i, lower_off_i} <= 2'h0;
    wait_st(hsfs_pkg::ST_SHUT, 40, n);
    cb <= 1'b1;
    cyc(10);
    chk(32'(power_ok_flag_o), 32'h0000_0001);
    wait_flag(1'b0, 14, n);
  endtask : s_latch_shut

  // ******************************************************************
  // Main sequence and watchdog
  // ******************************************************************
  initial begin
    s_regs();
    s_normal();
    s_ov();
    s_trim_faults();
    s_latch_shut();
    end_of_test();
  end

  // Whole run needs about 1300 cycles; a hang is cut well after that
  initial begin
    cyc(20000);
    n_errors++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
